/* File: rtl/cbhrs_pkg.sv */
package cbhrs_pkg;

  // Controller states, Gray coded along idle, memory, serial and hold.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_MEM  = 2'h1,
    ST_SIO  = 2'h3,
    ST_HOLD = 2'h2
  } cbhrs_state_t;

  // Cycle kinds that the core may request.
  typedef enum logic [2:0] {
    OP_RD      = 3'h0,
    OP_WR      = 3'h1,
    OP_SIO_OUT = 3'h2,
    OP_SIO_IN  = 3'h3,
    OP_EXT     = 3'h4
  } cbhrs_op_t;

  // Address index i stands for pin Ai; A13 is the most significant line.
  typedef struct packed {
    cbhrs_op_t   op;
    logic        fetch;
    logic [13:0] addr;
    logic [7:0]  wdata;
  } cbhrs_cmd_t;

  typedef struct packed {
    logic [13:0] addr;
    logic        addr_oe_n;
    logic [7:0]  data_out;
    logic        data_oe_n;
    logic        mem_cycle_n;
    logic        we_n;
    logic        read_direction;
    logic        ctl_oe_n;
    logic        bus_grant_ack;
    logic        instr_fetch_flag;
    logic        serial_io_strobe;
  } cbhrs_pins_t;

  localparam cbhrs_pins_t PINS_RST = '{
    addr: 14'h0000, addr_oe_n: 1'h0, data_out: 8'h00, data_oe_n: 1'h1,
    mem_cycle_n: 1'h1, we_n: 1'h1, read_direction: 1'h0, ctl_oe_n: 1'h0,
    bus_grant_ack: 1'h0, instr_fetch_flag: 1'h0, serial_io_strobe: 1'h0};

  localparam cbhrs_cmd_t CMD_RST = '{op: OP_RD, fetch: 1'h0, addr: 14'h0000, wdata: 8'h00};

  // Bit that carries the serial output value on the address bus.
  localparam int unsigned SIO_OUT_BIT = 13;

  // Serial I/O cycle length, long enough to cover the input synchroniser.
  localparam logic [2:0] SIO_CYCLES = 3'h4;

  // Cycles a memory cycle waits before it trusts ready, so that the
  // synchroniser no longer shows the ready of the previous cycle.
  localparam logic [2:0] MEM_SETTLE = 3'h2;

  // Synchroniser order: hold_n, ready, serial in, code bits 0..2, data 7..0.
  localparam int unsigned SYNC_W   = 14;
  localparam logic [13:0] SYNC_RST = 14'h2000;

  // Interrupt code as {bit0, bit1, bit2}.
  localparam logic [2:0] INT_CODE_L4  = 3'h7;
  localparam logic [2:0] INT_CODE_L3  = 3'h5;
  localparam logic [2:0] INT_CODE_L2  = 3'h4;
  localparam logic [2:0] INT_CODE_L1  = 3'h3;
  localparam logic [2:0] INT_CODE_RST = 3'h0;

endpackage : cbhrs_pkg

/* File: rtl/cbhrs_sync.sv */
`timescale 1ns/1ps
module cbhrs_sync #(
  parameter int unsigned W             = 1,
  parameter logic [W-1:0] RST_VAL      = '0
) (
  // Clock and reset.
  input  wire logic         ref_clk,
  input  wire logic         srst,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        meta[i] <= RST_VAL[i];
        dout[i] <= RST_VAL[i];
      end else begin
        meta[i] <= din[i];
        dout[i] <= meta[i];
      end
    end
  end

endmodule : cbhrs_sync

/* File: rtl/cbhrs_ctrl.sv */
`timescale 1ns/1ps
module cbhrs_ctrl
  import cbhrs_pkg::*;
(
  // Clock and reset.
  input  wire logic              ref_clk,
  input  wire logic              srst,
  // Core request side.
  input  wire logic              core_req,
  input  cbhrs_pkg::cbhrs_cmd_t  core_cmd,
  output logic                   core_ready,
  output logic                   core_ack,
  output logic [7:0]             core_rdata,
  output logic                   sio_ack,
  output logic                   sio_in_bit,
  output logic [2:0]             int_level,
  output logic                   reset_req,
  // Bus pins.
  output cbhrs_pkg::cbhrs_pins_t pins,
  input  wire logic [7:0]        data_in,
  input  wire logic              hold_n,
  input  wire logic              ready,
  input  wire logic              serial_io_in,
  input  wire logic              int_code_bit0,
  input  wire logic              int_code_bit1,
  input  wire logic              int_code_bit2
);
  import cbhrs_pkg::*;

  logic [SYNC_W-1:0] sync_q;
  logic              hold_s;
  logic              ready_s;
  logic              sin_s;
  logic [2:0]        code_s;
  logic [7:0]        data_s;
  cbhrs_state_t      st;
  cbhrs_state_t      next_st;
  cbhrs_cmd_t        cyc;
  cbhrs_cmd_t        next_cyc;
  logic [2:0]        cnt;
  logic [2:0]        next_cnt;
  logic              done;
  logic              cyc_is_mem;
  logic [13:0]       next_addr;
  logic              taken_in_hold;

  cbhrs_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .din     ({hold_n, ready, serial_io_in, int_code_bit0, int_code_bit1,
               int_code_bit2, data_in}),
    .dout    (sync_q)
  );

  assign hold_s     = ~sync_q[13];
  assign ready_s    = sync_q[12];
  assign sin_s      = sync_q[11];
  assign code_s     = sync_q[10:8];
  assign data_s     = sync_q[7:0];
  assign cyc_is_mem = (cyc.op == OP_RD) || (cyc.op == OP_WR);

  always_comb begin
    next_st  = st;
    next_cyc = cyc;
    next_cnt = cnt;
    done     = 1'b0;
    case (st)
      ST_IDLE: begin
        if (core_ready && core_req) begin
          next_cyc = core_cmd;
          if ((core_cmd.op == OP_RD) || (core_cmd.op == OP_WR)) begin
            next_cnt = MEM_SETTLE;
            next_st  = ST_MEM;
          end else begin
            next_cnt = SIO_CYCLES - 3'h1;
            next_st  = ST_SIO;
          end
        end else if (hold_s) begin
          // Hold is only entered from idle, between cycles.
          next_st = ST_HOLD;
        end
      end
      ST_MEM: begin
        // Wait states while ready is low.
        // The synchroniser still shows the previous cycle's ready at first.
        if (cnt != 3'h0) begin
          next_cnt = cnt - 3'h1;
        end else if (ready_s) begin
          done    = 1'b1;
          next_st = ST_IDLE;
        end
      end
      ST_SIO: begin
        if (cnt == 3'h0) begin
          done    = 1'b1;
          next_st = ST_IDLE;
        end else begin
          next_cnt = cnt - 3'h1;
        end
      end
      ST_HOLD: begin
        // Return to normal operation on release.
        if (!hold_s) begin
          next_st = ST_IDLE;
        end
      end
      default: next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st  <= ST_IDLE;
      cyc <= CMD_RST;
      cnt <= 3'h0;
      taken_in_hold <= 1'b0;
    end else begin
      st  <= next_st;
      cyc <= next_cyc;
      cnt <= next_cnt;
      if (st == ST_IDLE) begin
        taken_in_hold <= hold_s;
      end
    end
  end

  // A memory cycle that ends under a hold request admits one follower only.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      core_ready <= 1'b0;
    end else begin
      core_ready <= (next_st == ST_IDLE) && (!hold_s || ((st == ST_MEM) && !taken_in_hold));
    end
  end

  // Serial output value rides on the A13 line.
  always_comb begin
    next_addr = next_cyc.addr;
    if (next_cyc.op == OP_SIO_OUT) begin
      next_addr[SIO_OUT_BIT] = next_cyc.wdata[0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pins <= PINS_RST;
    end else begin
      pins.addr      <= next_addr;
      pins.data_out  <= next_cyc.wdata;
      // Float the bus and controls in hold.
      pins.addr_oe_n <= (next_st == ST_HOLD);
      pins.ctl_oe_n  <= (next_st == ST_HOLD);
      pins.bus_grant_ack <= (next_st == ST_HOLD);
      // Memory indicator marks memory addresses only.
      pins.mem_cycle_n <= (next_st != ST_MEM);
      pins.we_n      <= !((next_st == ST_MEM) && (next_cyc.op == OP_WR));
      pins.data_oe_n <= !((next_st == ST_MEM) && (next_cyc.op == OP_WR));
      // Direction high for memory reads only.
      pins.read_direction <= (next_st == ST_MEM) && (next_cyc.op == OP_RD);
      // Fetch flag in fetch memory cycles.
      pins.instr_fetch_flag <= (next_st == ST_MEM) && next_cyc.fetch;
      // Strobe for serial output and external instruction cycles.
      pins.serial_io_strobe <= (next_st == ST_SIO) && (next_cyc.op != OP_SIO_IN);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      core_ack   <= 1'b0;
      core_rdata <= 8'h00;
    end else begin
      core_ack <= done && cyc_is_mem;
      if (done && (cyc.op == OP_RD)) begin
        core_rdata <= data_s;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sio_ack    <= 1'b0;
      sio_in_bit <= 1'b0;
    end else begin
      sio_ack <= done && !cyc_is_mem;
      // Sample serial input at the end of an input cycle.
      if (done && (cyc.op == OP_SIO_IN)) begin
        sio_in_bit <= sin_s;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      int_level <= 3'h0;
      reset_req <= 1'b0;
    end else begin
      // Code zero is a reset request.
      reset_req <= (code_s == INT_CODE_RST);
      case (code_s)
        INT_CODE_L1: int_level <= 3'h1;
        INT_CODE_L2: int_level <= 3'h2;
        INT_CODE_L3: int_level <= 3'h3;
        INT_CODE_L4: int_level <= 3'h4;
        default:     int_level <= 3'h0;
      endcase
    end
  end

  chk_hold_floats: assert property (
    @(posedge ref_clk) disable iff (srst)
    pins.bus_grant_ack |-> pins.addr_oe_n && pins.ctl_oe_n && pins.data_oe_n)
    else $error("bus not floated during hold");

  chk_grant_from_idle: assert property (
    @(posedge ref_clk) disable iff (srst)
    $rose(pins.bus_grant_ack) |-> $past(st) == ST_IDLE && $past(hold_s))
    else $error("hold granted mid cycle or without request");

  chk_grant_release: assert property (
    @(posedge ref_clk) disable iff (srst)
    pins.bus_grant_ack && !hold_s |=> !pins.bus_grant_ack ##1 core_ready)
    else $error("grant not dropped after release");

  chk_wait_state: assert property (
    @(posedge ref_clk) disable iff (srst)
    st == ST_MEM && !ready_s |=> st == ST_MEM && !pins.mem_cycle_n && !core_ack)
    else $error("memory cycle left without ready");

  chk_mem_settle: assert property (
    @(posedge ref_clk) disable iff (srst)
    st == ST_MEM && cnt != 3'h0 |-> !done)
    else $error("memory cycle ended on stale ready");

  chk_fetch_flag: assert property (
    @(posedge ref_clk) disable iff (srst)
    pins.instr_fetch_flag |-> !pins.mem_cycle_n && cyc.fetch)
    else $error("fetch flag outside fetch cycle");

  chk_write_strobe: assert property (
    @(posedge ref_clk) disable iff (srst)
    !pins.we_n |-> !pins.data_oe_n && !pins.mem_cycle_n && cyc.op == OP_WR)
    else $error("write strobe without write data");

  chk_read_dir: assert property (
    @(posedge ref_clk) disable iff (srst)
    pins.read_direction |-> pins.data_oe_n && !pins.mem_cycle_n && pins.we_n)
    else $error("direction high outside read");

  chk_strobe_serial: assert property (
    @(posedge ref_clk) disable iff (srst)
    pins.serial_io_strobe |-> pins.mem_cycle_n && !pins.addr_oe_n && st == ST_SIO)
    else $error("strobe outside serial cycle");

  chk_int_decode: assert property (
    @(posedge ref_clk) disable iff (srst)
    code_s == INT_CODE_L1 |=> int_level == 3'h1 && !reset_req)
    else $error("level one code misdecoded");

  chk_reset_code: assert property (
    @(posedge ref_clk) disable iff (srst)
    code_s == INT_CODE_RST |=> reset_req && int_level == 3'h0)
    else $error("reset code not flagged");

  chk_sio_sample: assert property (
    @(posedge ref_clk) disable iff (srst)
    done && cyc.op == OP_SIO_IN |=> sio_ack && sio_in_bit == $past(sin_s))
    else $error("serial input not sampled");

endmodule : cbhrs_ctrl

/* File: test/cbhrs_far_model.sv */
`timescale 1ns/1ps
module cbhrs_far_model
  import cbhrs_pkg::*;
(
  // Clock and bus pins seen from outside.
  input  wire logic              ref_clk,
  input  cbhrs_pkg::cbhrs_pins_t pins,
  input  wire logic [3:0]        waits,
  // Memory and interface answers.
  output logic                   ready,
  output logic [7:0]             data_in,
  output logic                   serial_io_in,
  output logic [7:0]             wr_data,
  output logic                   sio_seen
);
  logic [3:0] cnt;
  initial begin
    cnt = 4'h0;
    ready = 1'h0;
    data_in = 8'h00;
    serial_io_in = 1'h0;
    wr_data = 8'h00;
    sio_seen = 1'h0;
  end
  always @(posedge ref_clk) begin
    cnt <= pins.mem_cycle_n ? 4'h0 : cnt + 4'h1;
    ready <= !pins.mem_cycle_n && cnt >= waits;
    // A released data bus toggles so that a stale byte never matches.
    data_in <= (pins.read_direction && pins.data_oe_n) ? pins.addr[7:0] ^ 8'h5A : ~data_in;
    if (!pins.we_n && !pins.data_oe_n) wr_data <= pins.data_out;
    if (pins.serial_io_strobe) sio_seen <= pins.addr[13];
    serial_io_in <= ^pins.addr[12:2];
  end
endmodule : cbhrs_far_model

/* File: test/cbhrs_ctrl_tb.sv */
`timescale 1ns/1ps
module cbhrs_ctrl_tb;
  import cbhrs_pkg::*;
  logic        ref_clk;
  logic        srst;
  logic        core_req;
  cbhrs_cmd_t  core_cmd;
  logic        core_ready;
  logic        core_ack;
  logic [7:0]  core_rdata;
  logic        sio_ack;
  logic        sio_in_bit;
  logic [2:0]  int_level;
  logic        reset_req;
  cbhrs_pins_t pins;
  logic [7:0]  data_in;
  logic        hold_n;
  logic        ready;
  logic        serial_io_in;
  logic [2:0]  int_code;
  logic [3:0]  waits;
  logic [7:0]  wr_data;
  logic        sio_seen;
  logic [7:0]  seen;
  int          mismatches;
  int          check_count;
  int          cyc;
  int          n;

  cbhrs_ctrl uut (.ref_clk(ref_clk), .srst(srst), .core_req(core_req), .core_cmd(core_cmd),
    .core_ready(core_ready), .core_ack(core_ack), .core_rdata(core_rdata), .sio_ack(sio_ack),
    .sio_in_bit(sio_in_bit), .int_level(int_level), .reset_req(reset_req), .pins(pins),
    .data_in(data_in), .hold_n(hold_n), .ready(ready), .serial_io_in(serial_io_in),
    .int_code_bit0(int_code[2]), .int_code_bit1(int_code[1]), .int_code_bit2(int_code[0]));
  cbhrs_far_model far (.ref_clk(ref_clk), .pins(pins), .waits(waits), .ready(ready),
    .data_in(data_in), .serial_io_in(serial_io_in), .wr_data(wr_data), .sio_seen(sio_seen));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // Issues one cycle, then gathers what the pins showed until its ack.
  task automatic run(input cbhrs_cmd_t c, input logic [3:0] w);
    waits <= w;
    core_req <= 1'h1;
    core_cmd <= c;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (core_ready !== 1'b1 && n < 40);
    core_req <= 1'h0;
    n = 0;
    seen = 8'h00;
    do begin
      @(negedge ref_clk);
      n++;
      seen |= {pins.instr_fetch_flag & pins.mem_cycle_n, pins.bus_grant_ack, !pins.data_oe_n,
               pins.instr_fetch_flag, pins.serial_io_strobe, !pins.we_n,
               pins.read_direction, !pins.mem_cycle_n};
    end while (n < 40 && core_ack !== 1'b1 && sio_ack !== 1'b1);
    chk(n < 40, 1'b1);
    @(posedge ref_clk);
  endtask : run

  task automatic t_mem;
    cbhrs_cmd_t c;
    int n0;
    c = '{op: OP_RD, fetch: 1'h1, addr: 14'h1234, wdata: 8'h00};
    run(c, 4'h0);
    n0 = n;
    chk(seen, 8'h13);
    chk(core_rdata, 8'h34 ^ 8'h5A);
    c.fetch = 1'h0;
    c.addr = 14'h0ABC;
    run(c, 4'h3);
    chk(seen, 8'h03);
    chk(n >= n0 + 3, 1'b1);
    chk(core_rdata, 8'hBC ^ 8'h5A);
    c.op = OP_WR;
    c.wdata = 8'hC5;
    run(c, 4'h1);
    chk(seen, 8'h25);
    chk(wr_data, 8'hC5);
    $display("t_mem done");
  endtask : t_mem

  task automatic t_sio;
    cbhrs_cmd_t c;
    c = '{op: OP_SIO_OUT, fetch: 1'h0, addr: 14'h0000, wdata: 8'h01};
    run(c, 4'h0);
    chk(seen, 8'h08);
    chk(sio_seen, 1'b1);
    chk(n, 5);
    c.wdata = 8'h00;
    run(c, 4'h0);
    chk(sio_seen, 1'b0);
    c.op = OP_EXT;
    c.addr = 14'h2003;
    run(c, 4'h0);
    chk(seen, 8'h08);
    for (int i = 0; i < 2; i++) begin
      c.op = OP_SIO_IN;
      c.addr = i ? 14'h0004 : 14'h000C;
      run(c, 4'h0);
      chk(seen, 8'h00);
      chk(sio_in_bit, ^c.addr[12:2]);
    end
    $display("t_sio done");
  endtask : t_sio

  task automatic t_hold;
    cbhrs_cmd_t c;
    int acks;
    c = '{op: OP_RD, fetch: 1'h0, addr: 14'h0055, wdata: 8'h00};
    hold_n <= 1'h0;
    run(c, 4'h4);
    chk(seen[6], 1'b0);
    chk(core_rdata, 8'h55 ^ 8'h5A);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (pins.bus_grant_ack !== 1'b1 && n < 10);
    chk({pins.addr_oe_n, pins.data_oe_n, pins.ctl_oe_n, core_ready}, 4'hE);
    n = 0;
    repeat (8) begin
      @(negedge ref_clk);
      n += (pins.bus_grant_ack === 1'b1);
    end
    chk(n, 8);
    @(posedge ref_clk);
    hold_n <= 1'h1;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (pins.bus_grant_ack !== 1'b0 && n < 6);
    chk({pins.addr_oe_n, pins.ctl_oe_n, core_ready}, 3'h1);
    @(posedge ref_clk);
    // A follower is served; a third request waits behind the hold.
    hold_n <= 1'h0;
    waits <= 4'h0;
    core_req <= 1'h1;
    core_cmd <= '{op: OP_WR, fetch: 1'h0, addr: 14'h0066, wdata: 8'h3C};
    do begin
      @(posedge ref_clk);
    end while (core_ready !== 1'b1);
    core_cmd <= '{op: OP_RD, fetch: 1'h0, addr: 14'h0077, wdata: 8'h00};
    do begin
      @(posedge ref_clk);
    end while (core_ready !== 1'b1);
    core_cmd <= '{op: OP_RD, fetch: 1'h0, addr: 14'h0011, wdata: 8'h00};
    n = 0;
    acks = 0;
    do begin
      @(negedge ref_clk);
      n++;
      acks += core_ack;
    end while (pins.bus_grant_ack !== 1'b1 && n < 20);
    chk(acks, 1);
    chk(pins.bus_grant_ack, 1'b1);
    chk(core_rdata, 8'h77 ^ 8'h5A);
    chk(wr_data, 8'h3C);
    @(posedge ref_clk);
    core_req <= 1'h0;
    hold_n <= 1'h1;
    repeat (4) @(posedge ref_clk);
    chk(pins.bus_grant_ack, 1'b0);
    $display("t_hold done");
  endtask : t_hold

  task automatic t_int;
    logic [2:0] exp;
    for (int i = 0; i < 8; i++) begin
      int_code <= i[2:0];
      repeat (4) @(posedge ref_clk);
      exp = (i == 7) ? 3'h4 : (i == 5) ? 3'h3 : (i == 4) ? 3'h2 : (i == 3) ? 3'h1 : 3'h0;
      chk(int_level, exp);
      chk(reset_req, i == 0);
    end
    $display("t_int done");
  endtask : t_int

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up;
    end
  end

  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial begin
    srst = 1'h1;
    core_req = 1'h0;
    core_cmd = CMD_RST;
    hold_n = 1'h1;
    int_code = 3'h7;
    waits = 4'h0;
    mismatches = 0;
    check_count = 0;
    cyc = 0;
    repeat (20) @(posedge ref_clk);
    chk(pins, PINS_RST);
    srst <= 1'h0;
    @(posedge ref_clk);
    t_mem;
    t_sio;
    t_hold;
    t_int;
    wrap_up;
  end
endmodule : cbhrs_ctrl_tb
